// ===== pkg/toc_map.svh
// Constants for the 16-bit timer output compare unit.
// Assumes inclusion by package and modules; definitions only.
`ifndef TOC_MAP_SVH
`define TOC_MAP_SVH

`define TOC_NUM_CHAN 3
`define TOC_CNT_W 16
`define TOC_BYTE_W 8
`define TOC_CHAN_A 0
// Waveform mode select codes
`define TOC_WGM_NORMAL 4'h0
`define TOC_WGM_PC8 4'h1
`define TOC_WGM_PC9 4'h2
`define TOC_WGM_PC10 4'h3
`define TOC_WGM_CTC_A 4'h4
`define TOC_WGM_FAST8 4'h5
`define TOC_WGM_FAST9 4'h6
`define TOC_WGM_FAST10 4'h7
`define TOC_WGM_PFC_CAP 4'h8
`define TOC_WGM_PFC_A 4'h9
`define TOC_WGM_PC_CAP 4'hA
`define TOC_WGM_PC_A 4'hB
`define TOC_WGM_CTC_CAP 4'hC
`define TOC_WGM_RSVD 4'hD
`define TOC_WGM_FAST_CAP 4'hE
`define TOC_WGM_FAST_A 4'hF
// Compare output mode codes
`define TOC_COM_NONE 2'h0
`define TOC_COM_TOGGLE 2'h1
`define TOC_COM_CLEAR 2'h2
`define TOC_COM_SET 2'h3
// Reset values
`define TOC_RST_VALUE 16'h0000
`define TOC_RST_BYTE 8'h00
`define TOC_RST_STATE 1'b0

`endif

// ===== pkg/toc_pkg.sv
// Types for the 16-bit timer output compare unit.
// Assumes toc_map.svh is on the include path.
`include "toc_map.svh"

package toc_pkg;

   typedef enum logic [1:0]
   {
      TOC_CLS_NONPWM = 2'b00,
      TOC_CLS_FAST = 2'b01,
      TOC_CLS_PHASE = 2'b10
   } toc_class_t;

   typedef struct packed
   {
      logic compare_irq_enable;
      logic [1:0] compare_output_mode;
   } toc_chan_ctrl_t;

   typedef struct packed
   {
      logic [`TOC_CNT_W-1:0] timer_count;
      logic timer_tick;
      logic count_top;
      logic count_bottom;
      logic count_down;
      logic count_write;
   } toc_cnt_status_t;

   typedef struct packed
   {
      logic [`TOC_CNT_W-1:0] active;
      logic [`TOC_CNT_W-1:0] buffer;
      logic armed;
   } toc_chan_state_t;

   typedef struct packed
   {
      logic [`TOC_BYTE_W-1:0] high_latch;
      logic block;
      logic [`TOC_NUM_CHAN-1:0] flag;
      logic [`TOC_NUM_CHAN-1:0] irq;
      logic [`TOC_NUM_CHAN-1:0] out_state;
   } toc_top_state_t;

endpackage : toc_pkg

// ===== core/toc_channel.sv
// One compare channel: buffer, active compare value and match detector.
// Assumes a same-clock counter source and one-cycle timer tick enables.
`timescale 1ns/1ps
`include "toc_map.svh"

module toc_channel
   import toc_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [`TOC_CNT_W-1:0] count, // Running counter value
   input wire logic tick, // Timer clock enable pulse
   input wire logic block, // Suppress match on this tick
   input wire logic buffered, // PWM double buffering in force
   input wire logic update, // Buffer to active transfer strobe
   input wire logic wr_en, // 16-bit write strobe
   input wire logic [`TOC_CNT_W-1:0] wr_data, // 16-bit write value
   output logic [`TOC_CNT_W-1:0] active_value, // Value in comparison
   output logic [`TOC_CNT_W-1:0] cpu_value, // Value seen by software
   output logic match_evt // Match one tick after detection
);

   toc_chan_state_t state_reg;
   toc_chan_state_t state_next;

   // Next state of the compare storage and detector
   always_comb
   begin
      state_next = state_reg;
      if (wr_en)
      begin
         state_next.buffer = wr_data;
         if (!buffered)
         begin
            state_next.active = wr_data;
         end
      end
      if (update && buffered)
      begin
         state_next.active = state_reg.buffer;
      end
      if (tick)
      begin
         // Equality over all 16 bits, dropped after a counter write
         state_next.armed = (count == state_reg.active) && !block;
      end
   end

   // Registered state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg.active <= `TOC_RST_VALUE;
         state_reg.buffer <= `TOC_RST_VALUE;
         state_reg.armed <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs; value only changes through writes or buffer transfer
   assign active_value = state_reg.active;
   assign cpu_value = state_reg.buffer;
   assign match_evt = tick && state_reg.armed;

endmodule : toc_channel

// ===== core/toc_top.sv
// Output compare unit of a 16-bit timer: three channels, flags, outputs.
// Assumes counter, prescaler and pin logic outside, all on clk.
//
// Contract
// - Each channel compares the full 16-bit count with its value.
// - Three independent channels A, B, C with own value, flag, controls.
// - A match sets the flag one timer clock after detection.
// - Flag with its interrupt enable set requests an interrupt.
// - Flag clears on interrupt service or software writing one.
// - Output state follows match per waveform and output modes.
// - Channel A value can serve as counter TOP.
// - PWM modes buffer writes; transfer at TOP or BOTTOM.
// - Normal and clear-on-compare modes write the active value directly.
// - Value changes only by writes; high byte read returns it directly.
// - High byte fills latch; low write loads all 16 bits at once.
// - Force strobe in non-PWM acts as match without flag or counter.
// - Counter write blocks matches of the next timer clock, all channels.
// - Output mode field is unbuffered and acts immediately.
// - Reset clears every output state bit.
// - Mode 0 normal; modes 4 and 12 clear on compare.
// - Output mode zero takes no action at a match.
`timescale 1ns/1ps
`include "toc_map.svh"

module toc_top
   import toc_pkg::*;
(
   input wire logic clk, // System clock, 125 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire toc_cnt_status_t cnt_status, // Counter value and events
   input wire logic [3:0] waveform_mode_sel, // Waveform mode select
   input wire toc_chan_ctrl_t [`TOC_NUM_CHAN-1:0] chan_ctrl, // Per channel
   input wire logic [`TOC_NUM_CHAN-1:0] force_compare_strobe, // Force
   input wire logic [`TOC_NUM_CHAN-1:0] compare_value_high_wr, // High
   input wire logic [`TOC_NUM_CHAN-1:0] compare_value_low_wr, // Low
   input wire logic [`TOC_BYTE_W-1:0] cpu_wdata, // Byte being written
   input wire logic [`TOC_NUM_CHAN-1:0] flag_clear_wr, // Write one
   input wire logic [`TOC_NUM_CHAN-1:0] irq_ack, // Interrupt serviced
   output logic [`TOC_NUM_CHAN-1:0] compare_match_flag, // Match flags
   output logic [`TOC_NUM_CHAN-1:0] compare_irq_req, // Interrupt requests
   output logic [`TOC_NUM_CHAN-1:0] compare_output_state, // Output state
   output logic [`TOC_NUM_CHAN-1:0][`TOC_CNT_W-1:0] compare_value, // Read
   output logic [`TOC_CNT_W-1:0] top_value_a // Channel A as TOP
);

   toc_top_state_t state_reg;
   toc_top_state_t state_next;
   toc_class_t mode_class;
   logic pwm_mode;
   logic update_at_bottom;
   logic buf_update;
   logic bottom_tick;
   logic [`TOC_NUM_CHAN-1:0] match_evt;
   logic [`TOC_NUM_CHAN-1:0][`TOC_CNT_W-1:0] active_value;

   // Mode class decode, shared by all channels
   always_comb
   begin
      case (waveform_mode_sel)
         `TOC_WGM_NORMAL, `TOC_WGM_CTC_A, `TOC_WGM_CTC_CAP, `TOC_WGM_RSVD:
            mode_class = TOC_CLS_NONPWM;
         `TOC_WGM_FAST8, `TOC_WGM_FAST9, `TOC_WGM_FAST10,
         `TOC_WGM_FAST_CAP, `TOC_WGM_FAST_A:
            mode_class = TOC_CLS_FAST;
         default:
            mode_class = TOC_CLS_PHASE;
      endcase
   end

   // Buffering and force permission; transfer point by mode
   assign pwm_mode = (mode_class != TOC_CLS_NONPWM);
   assign update_at_bottom = (waveform_mode_sel == `TOC_WGM_PFC_CAP) ||
      (waveform_mode_sel == `TOC_WGM_PFC_A);
   assign buf_update = cnt_status.timer_tick && pwm_mode &&
      (update_at_bottom ? cnt_status.count_bottom : cnt_status.count_top);
   assign bottom_tick = cnt_status.timer_tick && cnt_status.count_bottom;

   // Output state step for one channel at match, force or bottom
   function automatic logic wave_next(input logic cur, input logic evt,
      input logic frc, input logic [1:0] com, input logic is_a);
      logic nxt;
      logic down;
      nxt = cur;
      down = cnt_status.count_down;
      case (mode_class)
         TOC_CLS_NONPWM:
         begin
            if ((evt || frc) && com == `TOC_COM_TOGGLE) nxt = ~cur;
            if ((evt || frc) && com == `TOC_COM_CLEAR) nxt = 1'b0;
            if ((evt || frc) && com == `TOC_COM_SET) nxt = 1'b1;
         end
         TOC_CLS_FAST:
         begin
            if (evt && com == `TOC_COM_CLEAR) nxt = 1'b0;
            if (evt && com == `TOC_COM_SET) nxt = 1'b1;
            if (evt && com == `TOC_COM_TOGGLE && is_a &&
               waveform_mode_sel == `TOC_WGM_FAST_A) nxt = ~cur;
            if (bottom_tick && com == `TOC_COM_CLEAR) nxt = 1'b1;
            if (bottom_tick && com == `TOC_COM_SET) nxt = 1'b0;
         end
         default:
         begin
            if (evt && com == `TOC_COM_CLEAR) nxt = down;
            if (evt && com == `TOC_COM_SET) nxt = ~down;
            if (evt && com == `TOC_COM_TOGGLE && is_a &&
               (waveform_mode_sel == `TOC_WGM_PFC_A ||
               waveform_mode_sel == `TOC_WGM_PC_A)) nxt = ~cur;
         end
      endcase
      return nxt;
   endfunction : wave_next

   // One compare unit per channel
   genvar gi;
   generate
      for (gi = 0; gi < `TOC_NUM_CHAN; gi = gi + 1)
      begin : g_chan
         toc_channel u_chan
         (
            .clk(clk),
            .rst(rst),
            .count(cnt_status.timer_count),
            .tick(cnt_status.timer_tick),
            .block(state_reg.block),
            .buffered(pwm_mode),
            .update(buf_update),
            .wr_en(compare_value_low_wr[gi]),
            .wr_data({state_reg.high_latch, cpu_wdata}),
            .active_value(active_value[gi]),
            .cpu_value(compare_value[gi]),
            .match_evt(match_evt[gi])
         );
      end
   endgenerate

   // Next state of latch, blocking, flags, requests and output states
   always_comb
   begin
      state_next = state_reg;
      // Shared high byte latch; last high write wins
      for (int i = 0; i < `TOC_NUM_CHAN; i++)
      begin
         if (compare_value_high_wr[i])
         begin
            state_next.high_latch = cpu_wdata;
         end
      end
      // Block spans the next timer tick, even while ticks are stopped
      if (cnt_status.count_write)
      begin
         state_next.block = 1'b1;
      end
      else if (cnt_status.timer_tick)
      begin
         state_next.block = 1'b0;
      end
      for (int i = 0; i < `TOC_NUM_CHAN; i++)
      begin
         // Set wins over service or software clear
         state_next.flag[i] = (state_reg.flag[i] &&
            !(flag_clear_wr[i] || irq_ack[i])) || match_evt[i];
         state_next.irq[i] = state_next.flag[i] &&
            chan_ctrl[i].compare_irq_enable;
         // Mode field used live, state kept across mode changes
         state_next.out_state[i] = wave_next(state_reg.out_state[i],
            match_evt[i], force_compare_strobe[i] && !pwm_mode,
            chan_ctrl[i].compare_output_mode, i == `TOC_CHAN_A);
      end
   end

   // Registered state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg.high_latch <= `TOC_RST_BYTE;
         state_reg.block <= 1'b0;
         state_reg.flag <= '0;
         state_reg.irq <= '0;
         state_reg.out_state <= {`TOC_NUM_CHAN{`TOC_RST_STATE}};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign compare_match_flag = state_reg.flag;
   assign compare_irq_req = state_reg.irq;
   assign compare_output_state = state_reg.out_state;
   assign top_value_a = active_value[`TOC_CHAN_A];

endmodule : toc_top

// ===== tb/toc_top_asserts.sv
// Checker for toc_top: flags, requests, writes and output state.
// Bound into toc_top; one clock domain with async reset.
`timescale 1ns/1ps

module toc_chk
   import toc_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire toc_cnt_status_t cnt_status, // Counter
   input wire logic [3:0] waveform_mode_sel, // Mode
   input wire toc_chan_ctrl_t [2:0] chan_ctrl, // Controls
   input wire logic [2:0] force_compare_strobe, // Force
   input wire logic [2:0] compare_value_high_wr, // High write
   input wire logic [2:0] compare_value_low_wr, // Low write
   input wire logic [7:0] cpu_wdata, // Data
   input wire logic [2:0] flag_clear_wr, // Clear
   input wire logic [2:0] irq_ack, // Service
   input wire logic [2:0] compare_match_flag, // Flags
   input wire logic [2:0] compare_irq_req, // Requests
   input wire logic [2:0] compare_output_state, // Outputs
   input wire logic [2:0][15:0] compare_value, // Values
   input wire logic [15:0] top_value_a // TOP
);
   // Interrupt enables gathered
   logic [2:0] en;
   assign en = {chan_ctrl[2].compare_irq_enable,
      chan_ctrl[1].compare_irq_enable, chan_ctrl[0].compare_irq_enable};
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // Flags and requests
   flag_on_tick_a: assert property (
      $rose(compare_match_flag[1]) |-> $past(cnt_status.timer_tick))
      else $error("flag rose off tick");
   irq_gate_a: assert property (
      compare_irq_req == (compare_match_flag & $past(en)))
      else $error("bad request");
   sw_clear_a: assert property (
      compare_match_flag[1] && flag_clear_wr[1] && !cnt_status.timer_tick
      |=> !compare_match_flag[1]) else $error("no clear");
   // Compare value writes
   pair_write_a: assert property (
      compare_value_high_wr[2] ##1 compare_value_low_wr[2] |=>
      compare_value[2] == {$past(cpu_wdata, 2), $past(cpu_wdata)})
      else $error("bad pair");
   direct_ctc_a: assert property (
      waveform_mode_sel == 4'h4 && compare_value_low_wr[0]
      |=> top_value_a == compare_value[0]) else $error("not direct");
   buf_hold_a: assert property (
      waveform_mode_sel == 4'hF && !(cnt_status.timer_tick
      && cnt_status.count_top) |=> $stable(top_value_a))
      else $error("early transfer");
   // Output state
   force_set_a: assert property (
      waveform_mode_sel == 4'h0 && force_compare_strobe[0] &&
      chan_ctrl[0].compare_output_mode == 2'h3 |=> compare_output_state[0])
      else $error("force lost");
   out_hold_a: assert property (
      !$stable(compare_output_state) |-> $past(cnt_status.timer_tick
      || (|force_compare_strobe))) else $error("output moved");
   // Main scenarios reached
   cover property (compare_match_flag == 3'b110);
   cover property (cnt_status.count_write ##1 cnt_status.timer_tick);
   cover property (waveform_mode_sel == 4'hF && cnt_status.count_top);
   cover property (waveform_mode_sel == 4'h9 && cnt_status.count_bottom
      && cnt_status.timer_tick);
endmodule : toc_chk

bind toc_top toc_chk chk_u (.clk, .rst, .cnt_status, .waveform_mode_sel,
   .chan_ctrl, .force_compare_strobe, .compare_value_high_wr,
   .compare_value_low_wr, .cpu_wdata, .flag_clear_wr, .irq_ack,
   .compare_match_flag, .compare_irq_req, .compare_output_state,
   .compare_value, .top_value_a);

// ===== tb/tb_top.sv
// Directed bench for toc_top: writes, matches, blocking, force, buffering.
// Assumes toc_pkg and the checker are compiled before it.
`timescale 1ns/1ps
`include "toc_map.svh"

module tb_top
   import toc_pkg::*;
;
   logic clk, rst;
   toc_cnt_status_t cs;
   logic [3:0] wm;
   toc_chan_ctrl_t [2:0] cc;
   logic [2:0] frc, hw, lw, fc, ack, flg, irq, ost;
   logic [2:0][15:0] cv;
   logic [15:0] topa, v, pv;
   logic [7:0] wd;
   int err_count, cmp_count;

   toc_top dut_u (.clk(clk), .rst(rst), .cnt_status(cs),
      .waveform_mode_sel(wm), .chan_ctrl(cc), .force_compare_strobe(frc),
      .compare_value_high_wr(hw), .compare_value_low_wr(lw), .cpu_wdata(wd),
      .flag_clear_wr(fc), .irq_ack(ack), .compare_match_flag(flg),
      .compare_irq_req(irq), .compare_output_state(ost),
      .compare_value(cv), .top_value_a(topa));

   // Clock of 8 ns
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic cyc;
      @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // High byte to latch, then low byte loads all 16 bits
   task automatic wr(input int c, input logic [15:0] d);
      hw[c] = 1'b1;
      wd = d[15:8];
      cyc();
      hw[c] = 1'b0;
      lw[c] = 1'b1;
      wd = d[7:0];
      cyc();
      lw[c] = 1'b0;
   endtask : wr

   // One timer tick at count c, then an idle cycle
   task automatic tk(input logic [15:0] c, input logic t);
      cs.timer_count = c;
      cs.count_top = t;
      cs.timer_tick = 1'b1;
      cyc();
      cs.timer_tick = 1'b0;
      cyc();
   endtask : tk

   task automatic walk;
      tk(16'h1233, 1'b0);
      tk(16'h1234, 1'b0);
      chk(16'(flg), 16'h0000);
      tk(16'h1235, 1'b0);
   endtask : walk

   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // Test sequence
   initial
   begin
      cs = '0;
      wm = `TOC_WGM_NORMAL;
      cc = '0;
      {frc, hw, lw, fc, ack} = '0;
      wd = 8'h00;
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      cyc();
      cyc();
      rst = 1'b0;
      chk(16'(ost), 16'h0000);
      chk(cv[2], 16'h0000);
      $display("reset test done");
      cc[1] = '{1'b1, `TOC_COM_TOGGLE};
      wr(1, 16'h1234);
      wr(2, 16'h1234);
      chk(cv[1], 16'h1234);
      walk();
      chk(16'(flg), 16'h0006);
      chk(16'(irq), 16'h0002);
      chk(16'(ost), 16'h0002);
      fc = 3'b110;
      cyc();
      fc = 3'b000;
      chk(16'(flg | irq), 16'h0000);
      cc[1].compare_output_mode = `TOC_COM_CLEAR;
      walk();
      chk(16'(ost), 16'h0000);
      ack = 3'b110;
      cyc();
      ack = 3'b000;
      chk(16'(flg), 16'h0000);
      $display("match test done");
      cs.timer_count = 16'h1234;
      cs.count_write = 1'b1;
      cyc();
      cs.count_write = 1'b0;
      tk(16'h1234, 1'b0);
      tk(16'h1235, 1'b0);
      chk(16'(flg), 16'h0000);
      $display("block test done");
      cc[0] = '{1'b0, `TOC_COM_SET};
      frc = 3'b001;
      cyc();
      frc = 3'b000;
      chk(16'(ost), 16'h0001);
      chk(16'(flg), 16'h0000);
      wm = `TOC_WGM_FAST_A;
      cc[0].compare_output_mode = `TOC_COM_CLEAR;
      frc = 3'b001;
      cyc();
      frc = 3'b000;
      cyc();
      chk(16'(ost), 16'h0001);
      $display("force test done");
      pv = 16'h0000;
      for (int m = 0; m < 16; m++)
      begin
         wm = 4'(m);
         v = {4'(m), 12'h5A5};
         wr(0, v);
         if (m == 0 || m == 4 || m == 12 || m == 13)
            pv = v;
         chk(cv[0], v);
         chk(topa, pv);
      end
      chk(16'(ost), 16'h0001);
      tk(16'h0000, 1'b0);
      chk(topa, pv);
      tk(16'h0000, 1'b1);
      chk(topa, 16'hF5A5);
      $display("buffer test done");
      // Phase and frequency correct mode: transfer at bottom, dual slope
      wm = `TOC_WGM_PFC_A;
      cc[0] = '{1'b1, `TOC_COM_CLEAR};
      wr(0, 16'h0010);
      chk(topa, 16'hF5A5);
      tk(16'h0000, 1'b1);
      chk(topa, 16'hF5A5);
      cs.count_bottom = 1'b1;
      tk(16'h0000, 1'b0);
      cs.count_bottom = 1'b0;
      chk(topa, 16'h0010);
      tk(16'h0010, 1'b0);
      tk(16'h0011, 1'b0);
      chk(16'(ost), 16'h0000);
      chk(16'(flg), 16'h0001);
      chk(16'(irq), 16'h0001);
      cs.count_down = 1'b1;
      tk(16'h0010, 1'b0);
      tk(16'h000F, 1'b0);
      cs.count_down = 1'b0;
      chk(16'(ost), 16'h0001);
      $display("phase test done");
      wrap_up();
   end
endmodule : tb_top
